// ==== aof_pkg.sv ====
// aof_pkg: constants and types for the converter output formatter
// assumes a 32-bit APB slave and a 50 MHz pclk
package aof_pkg;
  localparam int unsigned DATA_W = 14;
  localparam int unsigned LANES = 7;
  localparam int unsigned CLK_MHZ = 50;
  // register byte offsets
  localparam logic [7:0] OFS_POWER = 8'h04;
  localparam logic [7:0] OFS_TIMING = 8'h08;
  localparam logic [7:0] OFS_OUTPUT_FORMAT_SELECT = 8'h0c;
  localparam logic [7:0] OFS_FORMAT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // timing register fields
  localparam int unsigned POS_DUTY = 0;
  localparam int unsigned POS_CKDLY = 1;
  localparam int unsigned POS_CKINV = 3;
  // output mode register fields
  localparam int unsigned POS_FMT = 0;
  localparam int unsigned POS_HIZ = 2;
  localparam int unsigned POS_TERM = 3;
  localparam int unsigned POS_CUR = 4;
  // data format register fields
  localparam int unsigned POS_SIGNED = 0;
  localparam int unsigned POS_RANDOMIZER_ENABLE = 1;
  localparam int unsigned POS_ALT = 2;
  localparam int unsigned POS_PAT = 3;
  // reset values
  localparam logic [7:0] RST_POWER = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'h00;
  localparam logic [7:0] RST_OUTPUT_FORMAT_SELECT = 8'h00;
  localparam logic [7:0] RST_FORMAT = 8'h00;
  // recovery times
  localparam int unsigned SLEEP_WAKE_US = 2000;
  localparam int unsigned SLEEP_WAKE_CYC = SLEEP_WAKE_US * CLK_MHZ;
  localparam int unsigned NAP_WAKE_SAMPLES = 100;
  // codes
  localparam logic [1:0] FMT_CMOS = 2'h0;
  localparam logic [1:0] FMT_DDR_LVDS = 2'h1;
  localparam logic [1:0] FMT_DDR_CMOS = 2'h2;
  localparam logic [2:0] PAT_OFF = 3'h0;
  localparam logic [2:0] PAT_ZERO = 3'h1;
  localparam logic [2:0] PAT_ONE = 3'h3;
  localparam logic [2:0] PAT_CHECK = 3'h5;
  localparam logic [2:0] PAT_ALT = 3'h7;
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_NAP = 2'h1;
  localparam logic [1:0] PWR_SLEEP = 2'h3;
  // drive current in units of 0.05 mA
  localparam logic [7:0] CUR_DEFAULT = 8'h46;
  localparam logic [15:0] CKB_PATTERN = 16'h5555;

  typedef struct packed {
    logic [DATA_W-1:0] code;
    logic ovf;
  } aof_sample_s;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_NAP = 3'b010,
    ST_SLEEP = 3'b100
  } aof_pwr_e;
endpackage

// ==== aof_formatter.sv ====
// aof_formatter: sample formatting, pin muxing and power states
// assumes samples arrive on pclk; enc_clk is a pin from the encode domain
// Operation
// RULE1 - ddr lvds: 7 pairs, ovf and clock own
// RULE2 - lvds current resets to 3.5 ma
// RULE3 - current field picks seven levels
// RULE4 - internal termination scales current by 1.6
// RULE5 - overflow flag high when out of range
// RULE6 - overflow delayed with its sample
// RULE7 - full rate: data changes on falling clock
// RULE8 - ddr: data changes on both edges
// RULE9 - clock delayed 0, 45, 90, 135 degrees
// RULE10 - software enables stabilizer with phase shift; duty_stabilizer_enable is decoded but drives no logic here
// RULE11 - clock inversion independent of delay
// RULE12 - offset binary default, signed flips msb
// RULE13 - out of range saturates code
// RULE14 - randomizer xors upper bits with lsb
// RULE15 - receiver xors back with lsb
// RULE16 - alternate polarity inverts odd bits
// RULE17 - polarity forces offset binary, independent of randomizer
// RULE18 - four test patterns on ovf and data
// RULE19 - test pattern overrides all formatting
// RULE20 - hiz disable covers all outputs; paired_bit_lane has no enable here and stays driven
// RULE21 - sleep powers down, 2 ms recovery
// RULE22 - nap: invalid for 100 samples after
// RULE23 - format codes cmos, ddr lvds, ddr cmos
// RULE24 - pattern codes 000,001,011,101,111
// RULE25 - current codes map to milliamps
// RULE26 - power codes normal, nap, sleep
//
// Decided for this implementation: the APB slave port and the register addresses.
module aof_formatter #(
  parameter int unsigned DATA_W = aof_pkg::DATA_W,
  parameter int unsigned SLEEP_WAKE_CYC = aof_pkg::SLEEP_WAKE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enc_clk,
  input wire logic [DATA_W-1:0] conv_code,
  input wire logic conv_over,
  input wire logic conv_under,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe_n,
  output logic overflow_flag,
  output logic overflow_flag_oe_n,
  output logic forwarded_sample_clock,
  output logic forwarded_sample_clock_oe_n,
  output logic [6:0] paired_bit_lane,
  output logic [7:0] diff_drive_current,
  output logic core_powered,
  output logic refs_powered,
  output logic data_valid
);
  logic [7:0] power_q;
  logic [7:0] timing_q;
  logic [7:0] output_format_select_q;
  logic [7:0] format_q;
  logic [1:0] power_state_select;
  logic duty_stabilizer_enable;
  logic [1:0] clock_delay_select;
  logic clock_polarity_flip;
  logic [1:0] output_format_select;
  logic output_hiz_enable;
  logic internal_termination_enable;
  logic [2:0] diff_drive_current_select;
  logic signed_format_select;
  logic randomizer_enable;
  logic alternate_polarity_enable;
  logic [2:0] pattern_select;
  logic wr_en;
  logic rd_hit;
  logic [2:0] enc_sync_q;
  logic enc_rise;
  logic enc_fall;
  logic [2:0] tick_q;
  aof_pkg::aof_sample_s raw;
  aof_pkg::aof_sample_s fmt;
  aof_pkg::aof_sample_s stage_q;
  aof_pkg::aof_sample_s out_q;
  logic alt_phase_q;
  logic ddr_half_q;
  logic clk_base_q;
  logic [DATA_W-1:0] code_shaped;
  logic [31:0] wake_q;
  aof_pkg::aof_pwr_e pwr_q;
  logic [7:0] cur_base;
  logic [8:0] cur_scaled;

  assign power_state_select = power_q[1:0];
  assign duty_stabilizer_enable = timing_q[aof_pkg::POS_DUTY];
  assign clock_delay_select = timing_q[aof_pkg::POS_CKDLY +: 2];
  assign clock_polarity_flip = timing_q[aof_pkg::POS_CKINV];
  assign output_format_select = output_format_select_q[aof_pkg::POS_FMT +: 2];
  assign output_hiz_enable = output_format_select_q[aof_pkg::POS_HIZ];
  assign internal_termination_enable = output_format_select_q[aof_pkg::POS_TERM];
  assign diff_drive_current_select = output_format_select_q[aof_pkg::POS_CUR +: 3];
  assign signed_format_select = format_q[aof_pkg::POS_SIGNED];
  assign randomizer_enable = format_q[aof_pkg::POS_RANDOMIZER_ENABLE];
  assign alternate_polarity_enable = format_q[aof_pkg::POS_ALT];
  assign pattern_select = format_q[aof_pkg::POS_PAT +: 3];

  // apb slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_hit = (paddr == aof_pkg::OFS_POWER) || (paddr == aof_pkg::OFS_TIMING) ||
    (paddr == aof_pkg::OFS_OUTPUT_FORMAT_SELECT) || (paddr == aof_pkg::OFS_FORMAT) ||
    (paddr == aof_pkg::OFS_STATUS);
  assign pslverr = psel && penable && !rd_hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_q <= aof_pkg::RST_POWER;
      timing_q <= aof_pkg::RST_TIMING;
      output_format_select_q <= aof_pkg::RST_OUTPUT_FORMAT_SELECT;
      format_q <= aof_pkg::RST_FORMAT;
    end
    else if (wr_en)
    begin
      case (paddr)
        aof_pkg::OFS_POWER: power_q <= {6'h00, pwdata[1:0]};
        aof_pkg::OFS_TIMING: timing_q <= {4'h0, pwdata[3:0]};
        aof_pkg::OFS_OUTPUT_FORMAT_SELECT: output_format_select_q <= {1'b0, pwdata[6:0]};
        aof_pkg::OFS_FORMAT: format_q <= {2'h0, pwdata[5:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        aof_pkg::OFS_POWER: prdata <= {24'h00_0000, power_q};
        aof_pkg::OFS_TIMING: prdata <= {24'h00_0000, timing_q};
        aof_pkg::OFS_OUTPUT_FORMAT_SELECT: prdata <= {24'h00_0000, output_format_select_q};
        aof_pkg::OFS_FORMAT: prdata <= {24'h00_0000, format_q};
        aof_pkg::OFS_STATUS: prdata <= {20'h0_0000, pwr_q, data_valid, cur_scaled[7:0]};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // encode clock sampled through two flops, third flop for edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enc_sync_q <= 3'h0;
    else
      enc_sync_q <= {enc_sync_q[1:0], enc_clk};
  end
  assign enc_rise = enc_sync_q[1] && !enc_sync_q[2];
  assign enc_fall = !enc_sync_q[1] && enc_sync_q[2];

  // eighth-period phase ticks: half period split into four pclk steps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_q <= 3'h0;
    else if (enc_rise || enc_fall)
      tick_q <= 3'h0;
    else if (tick_q != 3'h7)
      tick_q <= tick_q + 3'h1;
  end

  // range handling and saturation
  always_comb
  begin
    raw.ovf = conv_over || conv_under; // RULE5
    if (conv_over)
      raw.code = {DATA_W{1'b1}}; // RULE13
    else if (conv_under)
      raw.code = {DATA_W{1'b0}}; // RULE13
    else
      raw.code = conv_code;
  end

  // formatting chain, pattern has priority
  always_comb
  begin
    code_shaped = raw.code;
    if (signed_format_select && !alternate_polarity_enable) // RULE17
      code_shaped[DATA_W-1] = ~raw.code[DATA_W-1]; // RULE12
    if (randomizer_enable)
      code_shaped[DATA_W-1:1] = code_shaped[DATA_W-1:1] ^ {(DATA_W-1){code_shaped[0]}}; // RULE14
    if (alternate_polarity_enable)
      code_shaped = code_shaped ^ aof_pkg::CKB_PATTERN[DATA_W-1:0] << 1; // RULE16
    fmt.code = code_shaped;
    fmt.ovf = raw.ovf;
    case (pattern_select) // RULE19 RULE24
      aof_pkg::PAT_ZERO: fmt = '0; // RULE18
      aof_pkg::PAT_ONE: fmt = '1; // RULE18
      aof_pkg::PAT_ALT: fmt = alt_phase_q ? '1 : '0; // RULE18
      aof_pkg::PAT_CHECK:
      begin
        // ovf leads the pattern, code carries the remaining bits
        fmt.ovf = alt_phase_q; // RULE18
        fmt.code = alt_phase_q ? aof_pkg::CKB_PATTERN[DATA_W-1:0] :
          ~aof_pkg::CKB_PATTERN[DATA_W-1:0];
      end
      default: ;
    endcase
  end

  // pipeline: ovf travels in the same struct as its code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_q <= '0;
      out_q <= '0;
      alt_phase_q <= 1'b0;
    end
    else if (enc_rise)
    begin
      stage_q <= fmt; // RULE6
      out_q <= stage_q; // RULE6
      alt_phase_q <= ~alt_phase_q;
    end
  end

  // forwarded clock base: low half carries the data change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_base_q <= 1'b0;
      ddr_half_q <= 1'b0;
    end
    else
    begin
      if (enc_rise)
        ddr_half_q <= 1'b0;
      else if (enc_fall)
        ddr_half_q <= 1'b1;
      if ((enc_rise || enc_fall) && clock_delay_select == 2'h0)
        clk_base_q <= enc_fall; // RULE7 RULE8
      else if (tick_q == {1'b0, clock_delay_select} - 3'h1 && clock_delay_select != 2'h0)
        clk_base_q <= ddr_half_q; // RULE9
    end
  end

  // output pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_out <= '0;
      paired_bit_lane <= 7'h00;
      overflow_flag <= 1'b0;
      forwarded_sample_clock <= 1'b0;
    end
    else
    begin
      data_out <= out_q.code; // RULE7
      overflow_flag <= out_q.ovf;
      forwarded_sample_clock <= clk_base_q ^ clock_polarity_flip; // RULE11
      for (int i = 0; i < 7; i++)
        paired_bit_lane[i] <= ddr_half_q ? out_q.code[2*i+1] : out_q.code[2*i]; // RULE1 RULE8
    end
  end

  // output enables, low while driving
  always_comb
  begin
    data_oe_n = {DATA_W{output_hiz_enable}}; // RULE20
    if (output_format_select != aof_pkg::FMT_CMOS) // RULE23
      data_oe_n = {DATA_W{1'b1}};
    overflow_flag_oe_n = output_hiz_enable; // RULE20
    forwarded_sample_clock_oe_n = output_hiz_enable; // RULE20
  end

  // drive current code, 0.05 ma units
  always_comb
  begin
    case (diff_drive_current_select) // RULE3 RULE25
      3'h1: cur_base = 8'h50;
      3'h2: cur_base = 8'h5a;
      3'h4: cur_base = 8'h3c;
      3'h5: cur_base = 8'h32;
      3'h6: cur_base = 8'h2a;
      3'h7: cur_base = 8'h23;
      default: cur_base = aof_pkg::CUR_DEFAULT; // RULE2
    endcase
    cur_scaled = {1'b0, cur_base};
    if (internal_termination_enable)
      cur_scaled = 9'((16'(cur_base) * 16'h0008) / 16'h0005); // RULE4
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      diff_drive_current <= 8'h00;
    else
      diff_drive_current <= cur_scaled[8:1];
  end

  // power state machine and wake counting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwr_q <= aof_pkg::ST_ACTIVE;
      wake_q <= 32'h0000_0000;
    end
    else
    begin
      case (power_state_select) // RULE26
        aof_pkg::PWR_SLEEP:
        begin
          pwr_q <= aof_pkg::ST_SLEEP; // RULE21
          wake_q <= 32'(SLEEP_WAKE_CYC);
        end
        aof_pkg::PWR_NAP:
        begin
          pwr_q <= aof_pkg::ST_NAP; // RULE22
          if (pwr_q != aof_pkg::ST_SLEEP)
            wake_q <= 32'(aof_pkg::NAP_WAKE_SAMPLES);
        end
        default:
        begin
          pwr_q <= aof_pkg::ST_ACTIVE;
          if (wake_q != 32'h0000_0000 && (pwr_q == aof_pkg::ST_SLEEP || enc_rise ||
              wake_q > 32'(aof_pkg::NAP_WAKE_SAMPLES)))
            wake_q <= wake_q - 32'h0000_0001;
        end
      endcase
    end
  end

  assign core_powered = (pwr_q == aof_pkg::ST_ACTIVE);
  assign refs_powered = (pwr_q != aof_pkg::ST_SLEEP);
  assign data_valid = core_powered && (wake_q == 32'h0000_0000); // RULE21 RULE22
endmodule

// ==== aof_properties.sv ====
// aof_checker: port-level properties of the output formatter
// assumes a bind to aof_formatter, one pclk domain
module aof_checker #(
  parameter int unsigned DATA_W = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [DATA_W-1:0] data_oe_n,
  input wire logic overflow_flag_oe_n,
  input wire logic forwarded_sample_clock_oe_n,
  input wire logic core_powered,
  input wire logic refs_powered,
  input wire logic data_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_nap_end;
    refs_powered && !core_powered ##1 core_powered;
  endsequence
  sequence s_unmapped;
    psel && penable && (paddr == 8'h00 || paddr > 8'h14);
  endsequence
  property p_oe_tie;
    overflow_flag_oe_n == forwarded_sample_clock_oe_n;
  endproperty
  property p_data_oe;
    (data_oe_n == '0 && !overflow_flag_oe_n) || data_oe_n == '1;
  endproperty
  property p_ready;
    psel |-> pready;
  endproperty
  property p_err;
    s_unmapped |-> pslverr;
  endproperty
  property p_err_ph;
    pslverr |-> psel && penable;
  endproperty
  property p_valid;
    !core_powered ##1 !core_powered |-> !data_valid;
  endproperty
  property p_refs;
    !refs_powered |-> !core_powered;
  endproperty
  property p_nap;
    s_nap_end |-> !data_valid [*8];
  endproperty
  a_oe_tie: assert property (p_oe_tie)
    else $error("overflow and clock enables differ");
  a_data_oe: assert property (p_data_oe)
    else $error("data driven while outputs disabled");
  a_ready: assert property (p_ready)
    else $error("pready low");
  a_err: assert property (p_err)
    else $error("no error on unmapped access");
  a_err_ph: assert property (p_err_ph)
    else $error("error outside access phase");
  a_valid: assert property (p_valid)
    else $error("valid while core down");
  a_refs: assert property (p_refs)
    else $error("core up without references");
  a_nap: assert property (p_nap)
    else $error("valid too soon after nap");
endmodule

// ==== aof_receiver.sv ====
// aof_receiver: receiving logic latching full-rate samples
// assumes full-rate mode, no clock delay or inversion
module aof_receiver (
  input wire logic clk_in,
  input wire logic [13:0] d,
  input wire logic ovf,
  input wire logic randomizer_enable_en,
  input wire logic alt_en,
  output logic [14:0] rx,
  output logic [14:0] rx_prev,
  output logic [13:0] rec
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] t;
  always_ff @(posedge clk_in)
  begin
    rx <= {ovf, d};
    rx_prev <= rx;
  end
  always_comb
  begin
    t = rx[13:0] ^ (alt_en ? 14'h2aaa : 14'h0000);
    rec = randomizer_enable_en ? {t[13:1] ^ {13{t[0]}}, t[0]} : t;
  end
endmodule

// ==== aof_bench.sv ====
// adc_output_formatter_bench: self-checking bench for aof_formatter
// assumes aof_pkg, aof_receiver and aof_checker compiled first
module adc_output_formatter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, enc_clk = 0;
  logic conv_over = 0, conv_under = 0, pready, pslverr, overflow_flag, err, o, u;
  logic forwarded_sample_clock, overflow_flag_oe_n, forwarded_sample_clock_oe_n;
  logic core_powered, refs_powered, data_valid;
  logic [7:0] paddr = 0, diff_drive_current;
  logic [7:0] cur_tab [8] = '{8'h46, 8'h50, 8'h5a, 8'h00, 8'h3c, 8'h32, 8'h2a, 8'h23};
  logic [31:0] pwdata = 0, prdata, rd;
  logic [13:0] conv_code = 0, data_out, data_oe_n, rec, c;
  logic [14:0] rx, rx_prev;
  logic [6:0] paired_bit_lane;
  logic [2:0] f = 0;
  int error_cnt = 0, n_tests = 0, n;
  integer seed = 32'hb79f1706;
  always #10 pclk = ~pclk;
  always #80 enc_clk = ~enc_clk;
  aof_formatter #(.SLEEP_WAKE_CYC(50)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .enc_clk, .conv_code, .conv_over,
    .conv_under, .data_out, .data_oe_n, .overflow_flag, .overflow_flag_oe_n,
    .forwarded_sample_clock, .forwarded_sample_clock_oe_n, .paired_bit_lane,
    .diff_drive_current, .core_powered, .refs_powered, .data_valid);
  aof_receiver rx_model (.clk_in(forwarded_sample_clock), .d(data_out), .ovf(overflow_flag),
    .randomizer_enable_en(f[1]), .alt_en(f[2]), .rx, .rx_prev, .rec);
  function automatic logic [14:0] fmt(input logic [13:0] x, input logic ov, input logic un,
    input logic [2:0] g);
    logic [13:0] v;
    v = ov ? '1 : un ? '0 : x;
    if (g[0] && !g[2]) v[13] = ~v[13];
    if (g[1]) v[13:1] ^= {13{v[0]}};
    if (g[2]) v ^= 14'h2aaa;
    return {ov | un, v};
  endfunction
  function automatic logic [6:0] lanes(input logic [13:0] x, input logic odd);
    for (int i = 0; i < 7; i++)
      lanes[i] = x[2 * i + odd];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 20)
      error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wv();
    n = 0;
    while (data_valid !== 1'b1 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    final_report();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, aof_pkg::OFS_FORMAT, 0);
    chk(rd, 0);
    apb(0, aof_pkg::OFS_STATUS, 0);
    chk(rd[11:0], {3'b001, 1'b1, 8'h46});
    apb(1, 8'h20, 32'hffff);
    chk(err, 1);
    apb(0, 8'h20, 0);
    chk(err, 1);
    chk(rd, 0);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 3) continue;
      apb(1, aof_pkg::OFS_OUTPUT_FORMAT_SELECT, i << aof_pkg::POS_CUR | aof_pkg::FMT_DDR_LVDS);
      apb(0, aof_pkg::OFS_STATUS, 0);
      chk(rd[7:0], cur_tab[i]);
    end
    apb(1, aof_pkg::OFS_OUTPUT_FORMAT_SELECT, 32'h8);
    apb(0, aof_pkg::OFS_STATUS, 0);
    chk(rd[7:0], 8'h70);
    chk(diff_drive_current, 8'h38);
    apb(1, aof_pkg::OFS_OUTPUT_FORMAT_SELECT, 32'h4);
    repeat (3) @(negedge pclk);
    chk({overflow_flag_oe_n, forwarded_sample_clock_oe_n, data_oe_n}, 16'hffff);
    apb(1, aof_pkg::OFS_OUTPUT_FORMAT_SELECT, 0);
    for (int t = 0; t < 8; t++)
    begin
      apb(1, aof_pkg::OFS_TIMING, t << 1 | (t % 4 != 0));
      apb(0, aof_pkg::OFS_TIMING, 0);
      chk(rd, t << 1 | (t % 4 != 0));
    end
    apb(1, aof_pkg::OFS_TIMING, 0);
    wv();
    $display("test registers done");
    for (int i = 0; i < 24; i++)
    begin
      f = i < 8 ? i[2:0] : 3'($random(seed));
      c = i < 8 ? 14'h2000 ^ i[13:0] : 14'($random(seed));
      o = i % 5 == 4;
      u = i % 7 == 6;
      apb(1, aof_pkg::OFS_FORMAT, {29'h0, f});
      conv_code <= c;
      conv_over <= o;
      conv_under <= u;
      repeat (6) @(posedge enc_clk);
      @(negedge pclk);
      chk({overflow_flag, data_out}, fmt(c, o, u, f));
      chk(rec, 14'(fmt(c, o, u, {2'b00, f[0] & ~f[2]})));
    end
    $display("test formatting done");
    for (int i = 1; i < 8; i += 2)
    begin
      apb(1, aof_pkg::OFS_FORMAT, i << aof_pkg::POS_PAT | 7);
      repeat (6) @(posedge enc_clk);
      @(negedge pclk);
      chk(rx ^ rx_prev, i > 4 ? 15'h7fff : 15'h0);
      chk(rx, i == 1 ? 0 : i == 3 ? 15'h7fff : i == 5 ? 15'h2aaa ^ {15{rx[0]}} : {15{rx[0]}});
    end
    $display("test patterns done");
    apb(1, aof_pkg::OFS_FORMAT, 0);
    for (int m = 1; m < 3; m++)
    begin
      apb(1, aof_pkg::OFS_OUTPUT_FORMAT_SELECT, m);
      repeat (6) @(posedge enc_clk);
      for (int h = 0; h < 2; h++)
      begin
        repeat (2) @(negedge pclk iff forwarded_sample_clock === h[0]);
        chk(paired_bit_lane, lanes(c, h[0]));
      end
      chk(data_oe_n, 14'h3fff);
    end
    $display("test double rate done");
    apb(1, aof_pkg::OFS_POWER, aof_pkg::PWR_NAP);
    repeat (3) @(negedge pclk);
    chk({core_powered, refs_powered, data_valid}, 3'b010);
    apb(1, aof_pkg::OFS_POWER, aof_pkg::PWR_NORMAL);
    wv();
    chk(n >= 790 && n < 3000, 1);
    apb(1, aof_pkg::OFS_POWER, aof_pkg::PWR_SLEEP);
    repeat (3) @(negedge pclk);
    chk({core_powered, refs_powered, data_valid}, 3'b000);
    apb(1, aof_pkg::OFS_POWER, aof_pkg::PWR_NORMAL);
    wv();
    chk(n >= 49 && n < 3000, 1);
    $display("test power done");
    final_report();
  end
endmodule
bind aof_formatter aof_checker #(.DATA_W(DATA_W)) u_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .data_oe_n, .overflow_flag_oe_n, .forwarded_sample_clock_oe_n,
  .core_powered, .refs_powered, .data_valid);
